// ==== dv/ivm_assertions.sv ====
`default_nettype none
module ivm_checker
  import ivm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic coreAck,
  input wire logic [IVM_ADDR_W-1:0] vectorBaseAddress,
  input wire logic hostCmdVecValid,
  input wire logic [7:0] hostCmdVecOffset,
  input wire ivm_vector_type vecOut,
  input wire logic [IVM_NUM_SRC-1:0] srcAck
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Offset seen on the bus; base is held while an offer stands
  logic [23:0] off;
  logic [7:0] sl;
  logic v;
  // Host command override slot, word aligned
  logic hostOn;
  logic [7:0] hostSlot;
  assign hostOn = hostCmdVecValid && sl == 8'd33;
  assign hostSlot = {hostCmdVecOffset[7:1], 1'b0};
  assign off = vecOut.addr - vectorBaseAddress;
  assign sl = {2'h0, vecOut.source};
  assign v = vecOut.valid;
  // Offer taken: drop valid, pulse the slot's ack once
  sequence sDone;
    !v && srcAck == (42'h1 << $past(vecOut.source)) ##1 srcAck == '0;
  endsequence
  AST_FIXED: assert property (v && sl < 8 |-> vecOut.level == 2'h3 && off == 2 * sl)
    else $error("fixed slot wrong");
  AST_MASK_LVL: assert property (v && sl >= 8 |-> vecOut.level != 2'h3)
    else $error("maskable level wrong");
  AST_AUDIO: assert property (v && sl inside {[14:16]} |-> off == (sl == 16 ? 8'h2e : 8'h28 + 2 * (sl - 14)))
    else $error("audio slot wrong");
  AST_SAP0_RX: assert property (v && sl inside {[17:20]} |-> off == 8'h30 + 2 * (sl - 17))
    else $error("port0 rx slot wrong");
  AST_SAP0_TX: assert property (v && sl inside {[21:24]} |-> off == 8'h38 + 2 * (sl - 21))
    else $error("port0 tx slot wrong");
  AST_SER_HOST: assert property (v && sl inside {[25:30]} |-> off == (sl < 28 ? 8'h40 : 8'h42) + 2 * (sl - 25))
    else $error("serial host slot wrong");
  AST_PAR_HOST: assert property (v && sl inside {[31:33]} |-> off == (hostOn ? hostSlot : 8'h60 + 2 * (sl - 31)))
    else $error("parallel host slot wrong");
  AST_SAP1_RX: assert property (v && sl inside {[34:37]} |-> off == 8'h70 + 2 * (sl - 34))
    else $error("port1 rx slot wrong");
  AST_SAP1_TX: assert property (v && sl inside {[38:41]} |-> off == 8'h78 + 2 * (sl - 38))
    else $error("port1 tx slot wrong");
  AST_ACK: assert property (v && coreAck |=> sDone)
    else $error("ack handshake wrong");
endmodule : ivm_checker
bind interrupt_vector_map ivm_checker i_ivm_checker (.ref_clk(ref_clk), .reset(reset), .coreAck(coreAck),
  .vectorBaseAddress(vectorBaseAddress), .hostCmdVecValid(hostCmdVecValid), .hostCmdVecOffset(hostCmdVecOffset),
  .vecOut(vecOut), .srcAck(srcAck));
`default_nettype wire

// ==== dv/ivm_core_model.sv ====
`default_nettype none
module ivm_core_model
  import ivm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire ivm_vector_type vecOut,
  input wire logic [3:0] delay,
  output logic coreAck
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  // Fetch delay+1 cycles after the offer appears; pulse so a stale ack never hits the next offer
  always_ff @(posedge ref_clk) begin
    if (reset || !vecOut.valid || coreAck) begin
      coreAck <= 1'b0;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
      coreAck <= cnt == delay;
    end
  end
endmodule : ivm_core_model
`default_nettype wire

// ==== dv/tb_interrupt_vector_map.sv ====
`default_nettype none
module tb_interrupt_vector_map
  import ivm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [41:0] req = '0;
  logic [IVM_NUM_MASK-1:0][1:0] levelSel = '0;
  logic [1:0] coreMask = 2'h0;
  // Base near the top so the upper slots wrap
  logic [23:0] base = 24'hffffc0;
  logic hostVld = 1'b0;
  logic [7:0] hostOff = 8'h00;
  logic [3:0] delay = 4'h0;
  logic coreAck;
  ivm_vector_type vecOut;
  logic [IVM_NUM_SRC-1:0] srcAck;
  int fails = 0;
  int nChecks = 0;
  int cyc = 0;
  interrupt_vector_map i_interrupt_vector_map (.ref_clk(ref_clk), .reset(reset), .reqIn(ivm_req_type'(req)),
    .levelSel(levelSel), .coreMask(coreMask), .vectorBaseAddress(base), .hostCmdVecValid(hostVld),
    .hostCmdVecOffset(hostOff), .coreAck(coreAck), .vecOut(vecOut), .srcAck(srcAck));
  ivm_core_model i_ivm_core_model (.ref_clk(ref_clk), .reset(reset), .vecOut(vecOut), .delay(delay),
    .coreAck(coreAck));
  always #2 ref_clk = ~ref_clk;
  task automatic printVerdict();
    $display("checks %0d fails %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : printVerdict
  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      printVerdict();
    end
  end
  task automatic cmp(input string what, input logic [63:0] got, input logic [63:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // Slot index to bit of the packed request struct
  function automatic int bitOf(input int s);
    return s < 8 ? 34 + s : s < 14 ? 20 + s : s < 17 ? 41 - s : s < 21 ? 4 + s : s < 25 ? s - 4
      : s < 34 ? 41 - s : s < 38 ? s - 30 : s - 38;
  endfunction : bitOf
  // Slot offset by the slot table, host override included
  function automatic logic [7:0] expOff(input int s);
    if (s == 33 && hostVld) begin
      return {hostOff[7:1], 1'b0};
    end
    return 8'(s < 8 ? 2 * s : s < 14 ? 2 * s + 8 : s == 16 ? 8'h2e : s < 16 ? 8'h28 + 2 * (s - 14)
      : s < 25 ? 8'h30 + 2 * (s - 17) : s < 28 ? 8'h40 + 2 * (s - 25) : s < 31 ? 8'h48 + 2 * (s - 28)
      : s < 34 ? 8'h60 + 2 * (s - 31) : 8'h70 + 2 * (s - 34));
  endfunction : expOff
  // Raise a slot, check its offer and ack, release it in time
  task automatic serve(input int s, input logic [1:0] lv);
    int n;
    n = 0;
    @(posedge ref_clk);
    req[bitOf(s)] <= 1'b1;
    while (vecOut.valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cmp("source", vecOut.source, s[5:0]);
    cmp("level", vecOut.level, lv);
    cmp("addr", vecOut.addr, 24'(base + expOff(s)));
    while (srcAck[s] !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cmp("ack", srcAck, 42'h1 << s);
    @(posedge ref_clk);
    req[bitOf(s)] <= 1'b0;
  endtask : serve
  // Every slot alone, prompt and slow core, base near the wrap point
  task automatic tSlots();
    for (int s = 0; s < IVM_NUM_SRC; s++) begin
      delay <= s[0] ? 4'h6 : 4'h0;
      serve(s, s < 8 ? 2'h3 : 2'((s - 8) % 3));
    end
    $display("slots done");
  endtask : tSlots
  // Host command override replaces the default slot and wraps past the top
  task automatic tHost();
    @(posedge ref_clk);
    hostVld <= 1'b1;
    hostOff <= 8'h87;
    serve(33, 2'h1);
    hostVld <= 1'b0;
    $display("host done");
  endtask : tHost
  // Tie at level 2 goes to the lower slot; a level under the mask and the
  // disable code both stay silent
  task automatic tPrio();
    @(posedge ref_clk);
    coreMask <= 2'h1;
    levelSel[0] <= 2'h3;
    req[bitOf(8)] <= 1'b1;
    req[bitOf(20)] <= 1'b1;
    req[bitOf(40)] <= 1'b1;
    req[bitOf(22)] <= 1'b1;
    serve(22, 2'h2);
    serve(40, 2'h2);
    repeat (6) @(posedge ref_clk);
    req <= '0;
    #1;
    cmp("masked", vecOut.valid, 1'b0);
    $display("prio done");
  endtask : tPrio
  // Reset during an offer clears vector and ack; fixed slots ignore the mask
  task automatic tReset();
    @(posedge ref_clk);
    delay <= 4'h6;
    coreMask <= 2'h3;
    req[bitOf(5)] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cmp("pre reset", vecOut.valid, 1'b1);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp("reset vec", vecOut, '0);
    cmp("reset ack", srcAck, '0);
    @(posedge ref_clk);
    reset <= 1'b0;
    req[bitOf(5)] <= 1'b0;
    serve(5, 2'h3);
    $display("reset done");
  endtask : tReset
  initial begin
    for (int i = 0; i < IVM_NUM_MASK; i++) begin
      levelSel[i] <= 2'(i % 3);
    end
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    tSlots();
    tHost();
    tPrio();
    tReset();
    printVerdict();
  end
endmodule : tb_interrupt_vector_map
`default_nettype wire

// ==== src/interrupt_vector_map.sv ====
// Notes on behaviour
// - Eight lowest slots, 0x00 to 0x0E, are fixed nonmaskable level three.
// - Audio port 0 receive: data, even, exception, last at 0x30 to 0x36, maskable.
// - Audio port 0 transmit: same order at 0x38 to 0x3E, maskable.
// - Audio port 1 receive: same order at 0x70 to 0x76, maskable.
// - Audio port 1 transmit: same order at 0x78 to 0x7E, maskable.
// - Serial host port slots 0x40, 0x42, 0x44, 0x48, 0x4A, 0x4C; 0x46 spare.
// - Parallel host: 0x60 receive full, 0x62 transmit empty, 0x64 default command.
// - Audio transmitter: 0x28 underrun, 0x2A block done, 0x2E empty; 0x2C spare.
`default_nettype none
module interrupt_vector_map
  import ivm_pkg::*;
#(
  parameter int ADDR_W = IVM_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire ivm_req_type reqIn,
  input wire logic [IVM_NUM_MASK-1:0][1:0] levelSel,
  input wire logic [1:0] coreMask,
  input wire logic [ADDR_W-1:0] vectorBaseAddress,
  input wire logic hostCmdVecValid,
  input wire logic [7:0] hostCmdVecOffset,
  input wire logic coreAck,
  output ivm_vector_type vecOut,
  output logic [IVM_NUM_SRC-1:0] srcAck
);

  logic [IVM_NUM_SRC-1:0] reqFlat;
  logic found;
  logic [IVM_IDX_W-1:0] pickIdx;
  logic [1:0] pickLevel;
  logic [7:0] pickOffset;
  logic [ADDR_W-1:0] pickAddr;
  logic useHostSlot;
  logic [7:0] hostCmdSlot;
  ivm_vector_type offer;
  ivm_state_type state_q;
  ivm_state_type state_d;
  ivm_vector_type vec_q;
  ivm_vector_type vec_d;
  logic [IVM_NUM_SRC-1:0] srcAck_q;
  logic [IVM_NUM_SRC-1:0] srcAck_d;

  ////////////////////////////////////////////////////////////////////////////
  // Request lines laid out in slot order, matching the offset table
  // Nonmaskable group, never gated by the core mask
  assign reqFlat[7:0] = reqIn.fixedReq;

  // Direct-memory-access channels 0 to 5
  assign reqFlat[13:8] = reqIn.dmaReq;

  // Transmitter underrun, block done, then empty; 0x2C has no source
  assign reqFlat[14] = reqIn.audioUnderrun;
  assign reqFlat[15] = reqIn.audioBlockDone;
  assign reqFlat[16] = reqIn.audioDataEmpty;

  // Audio port 0: data, even, exception, last; receive before transmit
  assign reqFlat[20:17] = reqIn.sap0Rx;
  assign reqFlat[24:21] = reqIn.sap0Tx;

  // Serial host port; 0x46 has no source
  assign reqFlat[25] = reqIn.serHostTxData;
  assign reqFlat[26] = reqIn.serHostTxUnderrun;
  assign reqFlat[27] = reqIn.serHostRxNotEmpty;
  assign reqFlat[28] = reqIn.serHostRxFull;
  assign reqFlat[29] = reqIn.serHostRxOverrun;
  assign reqFlat[30] = reqIn.serHostBusError;

  // Parallel host port; the command keeps 0x64 unless overridden
  assign reqFlat[31] = reqIn.parHostRxFull;
  assign reqFlat[32] = reqIn.parHostTxEmpty;
  assign reqFlat[33] = reqIn.parHostCommand;

  // Audio port 1 in the same four-entry order as port 0
  assign reqFlat[37:34] = reqIn.sap1Rx;
  assign reqFlat[41:38] = reqIn.sap1Tx;

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration across all pending sources
  ivm_slot_select #(
    .NUM_SRC(IVM_NUM_SRC),
    .NUM_FIXED(IVM_NUM_FIXED)
  ) uSelect (
    .reqFlat(reqFlat),
    .levelSel(levelSel),
    .coreMask(coreMask),
    .found(found),
    .pickIdx(pickIdx),
    .pickLevel(pickLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host command slot; slots are word pairs, so the low bit is forced even
  assign hostCmdSlot = {hostCmdVecOffset[7:1], 1'b0};
  // Override reaches only the host command source; 0x64 stays the default
  assign useHostSlot = (pickIdx == IVM_IDX_HOST_CMD) && hostCmdVecValid;

  // Slot offset lookup for the current winner
  always_comb begin
    pickOffset = IVM_SLOT_OFFSET[pickIdx];
    if (useHostSlot) begin
      pickOffset = hostCmdSlot;
    end
  end

  // Base plus offset; carry beyond the address width wraps, so a base near
  // the top of memory folds the upper slots back to the bottom
  assign pickAddr = vectorBaseAddress + ADDR_W'(pickOffset);

  // Candidate vector from the current winner, latched only in IDLE
  always_comb begin
    offer.valid = found;
    offer.level = pickLevel;
    offer.source = pickIdx;
    offer.addr = pickAddr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offer sequencer: the vector stands until the core takes it, then one
  // settle cycle lets the source drop its line before the next pick, so a
  // level request already serviced is not offered twice
  always_comb begin
    state_d = state_q;
    case (state_q)
      IVM_IDLE: begin
        // No preemption: requests are looked at only here
        if (found) begin
          state_d = IVM_OFFER;
        end
      end
      IVM_OFFER: begin
        // Vector stands until the core takes it
        if (coreAck) begin
          state_d = IVM_SETTLE;
        end
      end
      IVM_SETTLE: begin
        // Source drops its line during this cycle
        state_d = IVM_IDLE;
      end
      default: begin
        state_d = IVM_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= IVM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offered vector: latched on a pick, held while it stands, valid dropped
  // on the edge that takes it
  always_comb begin
    vec_d = vec_q;
    case (state_q)
      IVM_IDLE: begin
        if (found) begin
          vec_d = offer;
        end
      end
      IVM_OFFER: begin
        if (coreAck) begin
          vec_d.valid = 1'b0;
        end
      end
      default: begin
        vec_d.valid = 1'b0;
      end
    endcase
  end

  // Vector register; all fields clear in reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vec_q.valid <= 1'b0;
      vec_q.level <= 2'h0;
      vec_q.source <= IVM_IDX_RESET;
      vec_q.addr <= IVM_ADDR_RESET;
    end else begin
      vec_q <= vec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source acknowledge: one pulse on the taken slot's bit, so a level
  // source can drop its line before the next pick
  always_comb begin
    srcAck_d = '0;
    if (state_q == IVM_OFFER && coreAck) begin
      srcAck_d[vec_q.source] = 1'b1;
    end
  end

  // Acknowledge register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      srcAck_q <= '0;
    end else begin
      srcAck_q <= srcAck_d;
    end
  end

  // Outputs straight from the registers
  assign vecOut = vec_q;
  assign srcAck = srcAck_q;

endmodule : interrupt_vector_map
`default_nettype wire

// ==== src/ivm_pkg.sv ====
`default_nettype none
package ivm_pkg;

  // Program address width of the core and slot count
  localparam int IVM_ADDR_W = 24;
  localparam int IVM_NUM_SRC = 42;
  localparam int IVM_NUM_FIXED = 8;
  localparam int IVM_NUM_MASK = IVM_NUM_SRC - IVM_NUM_FIXED;
  localparam int IVM_IDX_W = 6;

  // Level encodings
  localparam logic [1:0] IVM_LEVEL_NMI = 2'h3;
  localparam logic [1:0] IVM_LEVEL_OFF = 2'h3;

  // Reset values
  localparam logic [IVM_IDX_W-1:0] IVM_IDX_RESET = 6'h00;
  localparam logic [IVM_ADDR_W-1:0] IVM_ADDR_RESET = 24'h000000;

  // Index of the parallel host command source in slot order
  localparam logic [IVM_IDX_W-1:0] IVM_IDX_HOST_CMD = 6'h21;

  // Slot offsets from the vector base, in slot order; each slot is two words
  localparam logic [7:0] IVM_SLOT_OFFSET [IVM_NUM_SRC] = '{
    8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e,
    8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20, 8'h22,
    8'h28, 8'h2a, 8'h2e,
    8'h30, 8'h32, 8'h34, 8'h36,
    8'h38, 8'h3a, 8'h3c, 8'h3e,
    8'h40, 8'h42, 8'h44, 8'h48, 8'h4a, 8'h4c,
    8'h60, 8'h62, 8'h64,
    8'h70, 8'h72, 8'h74, 8'h76,
    8'h78, 8'h7a, 8'h7c, 8'h7e
  };

  // Request lines, grouped per peripheral; four-entry groups are
  // [0] data, [1] even data, [2] data with exception, [3] last slot
  typedef struct packed {
    logic [7:0] fixedReq;
    logic [5:0] dmaReq;
    logic audioUnderrun;
    logic audioBlockDone;
    logic audioDataEmpty;
    logic [3:0] sap0Rx;
    logic [3:0] sap0Tx;
    logic serHostTxData;
    logic serHostTxUnderrun;
    logic serHostRxNotEmpty;
    logic serHostRxFull;
    logic serHostRxOverrun;
    logic serHostBusError;
    logic parHostRxFull;
    logic parHostTxEmpty;
    logic parHostCommand;
    logic [3:0] sap1Rx;
    logic [3:0] sap1Tx;
  } ivm_req_type;

  // Vector offered to the core
  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [IVM_IDX_W-1:0] source;
    logic [IVM_ADDR_W-1:0] addr;
  } ivm_vector_type;

  // Offer sequencer, Gray coded along IDLE, OFFER, SETTLE
  typedef enum logic [1:0] {
    IVM_IDLE = 2'b00,
    IVM_OFFER = 2'b01,
    IVM_SETTLE = 2'b11
  } ivm_state_type;

endpackage : ivm_pkg
`default_nettype wire

// ==== src/ivm_slot_select.sv ====
`default_nettype none
module ivm_slot_select
  import ivm_pkg::*;
#(
  parameter int NUM_SRC = IVM_NUM_SRC,
  parameter int NUM_FIXED = IVM_NUM_FIXED
) (
  input wire logic [NUM_SRC-1:0] reqFlat,
  input wire logic [NUM_SRC-NUM_FIXED-1:0][1:0] levelSel,
  input wire logic [1:0] coreMask,
  output logic found,
  output logic [IVM_IDX_W-1:0] pickIdx,
  output logic [1:0] pickLevel
);

  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0][1:0] effLevel;

  ////////////////////////////////////////////////////////////////////////////
  // Per-source level and eligibility
  for (genvar i = 0; i < NUM_SRC; i++) begin : gSrc
    if (i < NUM_FIXED) begin : gFixed
      // Lowest eight slots are always nonmaskable
      assign effLevel[i] = IVM_LEVEL_NMI;
      assign eligible[i] = reqFlat[i];
    end else begin : gMask
      // Programmed 0 to 2; the unused code 3 disables the source
      assign effLevel[i] = levelSel[i-NUM_FIXED];
      assign eligible[i] = reqFlat[i] && (levelSel[i-NUM_FIXED] != IVM_LEVEL_OFF)
        && (levelSel[i-NUM_FIXED] >= coreMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Highest level wins; lowest slot wins a tie
  always_comb begin
    found = 1'b0;
    pickIdx = IVM_IDX_RESET;
    pickLevel = 2'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (eligible[k] && (!found || effLevel[k] >= pickLevel)) begin
        found = 1'b1;
        pickIdx = IVM_IDX_W'(k);
        pickLevel = effLevel[k];
      end
    end
  end

endmodule : ivm_slot_select
`default_nettype wire
